// ==== dma_clear_model.sv ====
`timescale 1ns/10ps
// ==========================================================================
// dma flag clear request source, held for a chosen number of states
module dma_clear_model (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  // request from bench
  input  wire logic       start_i,
  input  wire logic [3:0] bits_i,
  input  wire logic [3:0] len_i,
  // clear request to timer
  output logic      [3:0] dma_clr_o
);
  logic [3:0] left_ff;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      left_ff   <= 4'h0;
      dma_clr_o <= 4'h0;
    end else if (start_i) begin
      left_ff   <= len_i - 4'h1;
      dma_clr_o <= bits_i;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end else begin
      dma_clr_o <= 4'h0;
    end
  end
endmodule // dma_clear_model

// ==== multi_channel_timer.sv ====
`timescale 1ns/10ps
`include "multi_channel_timer_regs.svh"
// Behaviour
// R1: capture loses to same-cycle GR write, flag sets
// R2: counter write beats increment in that cycle
// R3: write beats overflow clear, wrap flag sets
// R4: event setting flag beats zero-write clear
// R5: duty write colliding with transfer stores OR
// R6: software updates duty only via buffer; here TMR_DUTY writes also load duty directly
// R7: DMA clear beats flag setting event
// R8: DMA clear applies every cycle it is held
// R9: zero-write halts down-counter at next underflow
// R10: start from zero: no pulse, flag still sets
// R11: capture works whether counter runs or not
// R12: underflow halt discards same-cycle counter write
// R13: underflow beats same-cycle start bit write
// R14: software sets prescale and modes before start
// R15: software reads flag before zero write
// R16: first match after zero start may lag
// R17: run clear only stops counting, outputs hold
// R18: interval bits 10-13 rising edge raise requests
// R19: DMA auto clear only for timer space
// R20: repeat event voids down-flag zero write
// R21: standby clears regs, channel-1 output after exit
module multi_channel_timer
  import multi_channel_timer_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // capture pins
  input  wire logic        CAP0_I,
  input  wire logic        CAP1_I,
  // dma flag clear and standby
  input  wire logic [3:0]  DMA_CLR_I,
  input  wire logic        STBY_I,
  // timer outputs
  output logic             CMP1_O,
  output logic             PWM_O,
  output logic             OSP_O,
  output logic             ITV_IRQ_O,
  output logic             AD_START_O
);

  // ========================================================================
  // capture pin synchronisers
  logic [2:0] cap0_sy_ff;
  logic [2:0] cap1_sy_ff;
  logic       cap0_ev;
  logic       cap1_ev;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cap0_sy_ff <= 3'h0;
      cap1_sy_ff <= 3'h0;
    end else begin
      cap0_sy_ff <= {cap0_sy_ff[1:0], CAP0_I};
      cap1_sy_ff <= {cap1_sy_ff[1:0], CAP1_I};
    end
  end

  assign cap0_ev = cap0_sy_ff[1] & ~cap0_sy_ff[2];
  assign cap1_ev = cap1_sy_ff[1] & ~cap1_sy_ff[2];

  // ========================================================================
  // timer state
  tmr_state_t st_ff;
  tmr_state_t nxt_st;
  logic       tick;
  logic       wr_cnt0;
  logic       wr_cnt1;
  logic       wr_gr1;
  logic       wr_cnt2;
  logic       wr_duty;
  logic       wr_one_shot_down_counter;
  logic       wr_dstart;
  logic       wr_flags;
  logic       wr_dflag;
  logic       capmode;
  logic       match1;
  logic       ovf1;
  logic       cyc_m;
  logic       duty_m;
  logic       unf;
  logic       ds_start;
  logic       stby_in;
  logic [3:0] ev;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.itv_irq  = 1'b0;
    nxt_st.ad_start = 1'b0;
    nxt_st.rd_data  = `RST_WORD;
    wr_cnt0   = WR_I && (ADDR_I == `TMR_CNT0);
    wr_cnt1   = WR_I && (ADDR_I == `TMR_CNT1);
    wr_gr1    = WR_I && (ADDR_I == `TMR_GR1);
    wr_cnt2   = WR_I && (ADDR_I == `TMR_CNT2);
    wr_duty   = WR_I && (ADDR_I == `TMR_DUTY);
    wr_one_shot_down_counter   = WR_I && (ADDR_I == `TMR_ONE_SHOT_DOWN_COUNTER);
    wr_dstart = WR_I && (ADDR_I == `TMR_DSTART);
    wr_flags  = WR_I && (ADDR_I == `TMR_FLAGS);
    wr_dflag  = WR_I && (ADDR_I == `TMR_DFLAG);
    capmode   = st_ff.ctrl[`CTRL_CAPMODE];
    stby_in   = STBY_I && !st_ff.stby_d;
    // prescaler tick
    tick = (st_ff.pre_cnt == st_ff.psc);
    nxt_st.pre_cnt = tick ? 8'h00 : st_ff.pre_cnt + 8'h01;
    // plain configuration writes
    if (WR_I) begin
      case (ADDR_I)
        `TMR_RUN:  nxt_st.run      = WDATA_I[2:0];
        `TMR_PSC:  nxt_st.psc      = WDATA_I[7:0];
        `TMR_CTRL: nxt_st.ctrl     = WDATA_I[11:0];
        `TMR_CYC:  nxt_st.cyc      = WDATA_I;
        `TMR_BUF:  nxt_st.duty_buf = WDATA_I;
        default:   nxt_st.ctrl     = st_ff.ctrl;
      endcase
    end
    // channel 0 counter and interval detection
    if (wr_cnt0) begin
      nxt_st.cnt0 = WDATA_I; // R2
    end else if (st_ff.run[0] && tick) begin
      nxt_st.cnt0 = st_ff.cnt0 + 16'h0001; // R17
    end
    for (int b = 0; b < `ITV_BITS; b++) begin
      if (!st_ff.cnt0[`ITV_LSB + b] && nxt_st.cnt0[`ITV_LSB + b]) begin // R18
        if (st_ff.ctrl[`CTRL_ITVE + b]) begin
          nxt_st.itv_irq = 1'b1;
        end
        if (st_ff.ctrl[`CTRL_ITVAD + b]) begin
          nxt_st.ad_start = 1'b1;
        end
      end
    end
    ev = 4'h0;
    if (cap0_ev) begin
      nxt_st.icr0 = st_ff.cnt0; // R11
      ev[`FLG_CAP0] = 1'b1;
    end
    // channel 1 compare or capture
    match1 = st_ff.run[1] && tick && !capmode && (st_ff.cnt1 == st_ff.gr1);
    ovf1   = st_ff.run[1] && tick && (st_ff.cnt1 == 16'hFFFF);
    if (wr_cnt1) begin
      nxt_st.cnt1 = WDATA_I; // R3
    end else if (match1 && st_ff.ctrl[`CTRL_CLR1]) begin
      nxt_st.cnt1 = `RST_WORD;
    end else if (st_ff.run[1] && tick) begin
      nxt_st.cnt1 = st_ff.cnt1 + 16'h0001;
    end
    ev[`FLG_WRAP1] = ovf1; // R3
    ev[`FLG_MATCH1] = match1 || (capmode && cap1_ev); // R1
    if (match1) begin
      nxt_st.cmp_out = 1'b1;
    end
    if (wr_gr1) begin
      nxt_st.gr1 = WDATA_I; // R1
    end else if (capmode && cap1_ev) begin
      nxt_st.gr1 = st_ff.cnt1; // R11
    end
    // channel 2 pwm with duty buffer
    cyc_m  = st_ff.run[2] && tick && (st_ff.cnt2 == st_ff.cyc);
    duty_m = st_ff.run[2] && tick && (st_ff.cnt2 == st_ff.duty);
    if (wr_cnt2) begin
      nxt_st.cnt2 = WDATA_I;
    end else if (cyc_m) begin
      nxt_st.cnt2 = `RST_WORD;
    end else if (st_ff.run[2] && tick) begin
      nxt_st.cnt2 = st_ff.cnt2 + 16'h0001; // R16
    end
    if (cyc_m && wr_duty) begin
      nxt_st.duty = st_ff.duty_buf | WDATA_I; // R5
    end else if (cyc_m) begin
      nxt_st.duty = st_ff.duty_buf;
    end else if (wr_duty) begin
      nxt_st.duty = WDATA_I;
    end
    if (cyc_m) begin
      nxt_st.pwm_out = 1'b1;
    end else if (duty_m) begin
      nxt_st.pwm_out = 1'b0;
    end
    ev[`FLG_CYC2] = cyc_m;
    // one-shot down-counter
    unf = (st_ff.os == OS_RUN) && tick && (st_ff.one_shot_down_counter == `RST_WORD);
    ds_start = (wr_dstart && WDATA_I[0]) ||
               (match1 && st_ff.ctrl[`CTRL_LINK]);
    case (st_ff.os)
      OS_IDLE: begin
        if (ds_start) begin
          nxt_st.os  = OS_RUN;
          nxt_st.osp = (st_ff.one_shot_down_counter != `RST_WORD); // R10
        end
      end
      OS_RUN: begin
        if (unf) begin
          nxt_st.os  = OS_IDLE; // R9 R13
          nxt_st.osp = 1'b0;
        end
      end
      default: begin
        nxt_st.os  = OS_IDLE;
        nxt_st.osp = 1'b0;
      end
    endcase
    if (unf) begin
      nxt_st.one_shot_down_counter = `RST_WORD; // R12
    end else if (wr_one_shot_down_counter) begin
      nxt_st.one_shot_down_counter = WDATA_I; // R9
    end else if ((st_ff.os == OS_RUN) && tick) begin
      nxt_st.one_shot_down_counter = st_ff.one_shot_down_counter - 16'h0001;
    end
    // channel flags: dma clear, then event, then software clear
    for (int i = 0; i < 4; i++) begin
      if (DMA_CLR_I[i]) begin
        nxt_st.flags[i] = 1'b0; // R7 R8 R19
        nxt_st.farm[i]  = 1'b0;
      end else if (ev[i]) begin
        nxt_st.flags[i] = 1'b1; // R4: event sets flag
      end else if (wr_flags && !WDATA_I[i] && st_ff.farm[i]) begin
        nxt_st.flags[i] = 1'b0;
        nxt_st.farm[i]  = 1'b0;
      end
    end
    // down-counter flag: repeat event disarms the clear
    if (unf) begin
      nxt_st.dflag = 1'b1; // R4
      if (st_ff.dflag) begin
        nxt_st.darm = 1'b0; // R20
      end
    end else if (wr_dflag && !WDATA_I[0] && st_ff.darm) begin
      nxt_st.dflag = 1'b0;
      nxt_st.darm  = 1'b0;
    end
    // register reads
    if (RD_I) begin
      case (ADDR_I)
        `TMR_RUN:    nxt_st.rd_data = {13'h0000, st_ff.run};
        `TMR_PSC:    nxt_st.rd_data = {8'h00, st_ff.psc};
        `TMR_CTRL:   nxt_st.rd_data = {4'h0, st_ff.ctrl};
        `TMR_CNT0:   nxt_st.rd_data = st_ff.cnt0;
        `TMR_ICR0:   nxt_st.rd_data = st_ff.icr0;
        `TMR_CNT1:   nxt_st.rd_data = st_ff.cnt1;
        `TMR_GR1:    nxt_st.rd_data = st_ff.gr1;
        `TMR_CNT2:   nxt_st.rd_data = st_ff.cnt2;
        `TMR_CYC:    nxt_st.rd_data = st_ff.cyc;
        `TMR_BUF:    nxt_st.rd_data = st_ff.duty_buf;
        `TMR_DUTY:   nxt_st.rd_data = st_ff.duty;
        `TMR_ONE_SHOT_DOWN_COUNTER:   nxt_st.rd_data = st_ff.one_shot_down_counter;
        `TMR_DSTART: nxt_st.rd_data = {15'h0000, st_ff.os == OS_RUN};
        `TMR_FLAGS: begin
          nxt_st.rd_data = {12'h000, st_ff.flags};
          nxt_st.farm = nxt_st.farm | (st_ff.flags & nxt_st.flags); // R15
        end
        `TMR_DFLAG: begin
          nxt_st.rd_data = {15'h0000, st_ff.dflag};
          nxt_st.darm = st_ff.dflag & nxt_st.dflag; // R15
        end
        `TMR_STATUS: nxt_st.rd_data = {12'h000, st_ff.osp, st_ff.pwm_out,
                                       st_ff.cmp_out, st_ff.os == OS_RUN};
        default:     nxt_st.rd_data = `RST_WORD;
      endcase
    end
    // software standby
    if (stby_in) begin
      nxt_st         = '0; // R21
      nxt_st.psc     = `RST_PSC;
      nxt_st.os      = OS_IDLE;
      nxt_st.cmp_out = st_ff.cmp_out;
    end else if (!STBY_I && st_ff.stby_d) begin
      nxt_st.cmp_out = 1'b0; // R21
    end
    nxt_st.stby_d = STBY_I;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_ff     <= '0;
      st_ff.psc <= `RST_PSC;
      st_ff.os  <= OS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // outputs
  assign RDATA_O    = st_ff.rd_data;
  assign CMP1_O     = st_ff.cmp_out;
  assign PWM_O      = st_ff.pwm_out;
  assign OSP_O      = st_ff.osp;
  assign ITV_IRQ_O  = st_ff.itv_irq;
  assign AD_START_O = st_ff.ad_start;

  // ========================================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence unf_s;
    (st_ff.os == OS_RUN) && tick && (st_ff.one_shot_down_counter == 16'h0000) && !stby_in;
  endsequence

  sequence zero_start_s;
    (st_ff.os == OS_IDLE) && (st_ff.one_shot_down_counter == 16'h0000) && ds_start &&
    !wr_one_shot_down_counter && !stby_in;
  endsequence

  chk_gr_write_wins: assert property ( // R1
    wr_gr1 && capmode && cap1_ev && !DMA_CLR_I[1] && !stby_in |=>
    st_ff.gr1 == $past(WDATA_I) && st_ff.flags[1])
    else $error("capture overrode gr write");

  chk_cnt_write_wins: assert property ( // R2
    wr_cnt0 && st_ff.run[0] && tick && !stby_in |=>
    st_ff.cnt0 == $past(WDATA_I))
    else $error("increment overrode counter write");

  chk_ovf_write_wins: assert property ( // R3
    ovf1 && wr_cnt1 && !DMA_CLR_I[2] && !stby_in |=>
    st_ff.cnt1 == $past(WDATA_I) && st_ff.flags[2])
    else $error("overflow overrode counter write");

  chk_set_over_clear: assert property ( // R4
    wr_flags && !WDATA_I[3] && cyc_m && !DMA_CLR_I[3] && !stby_in |=>
    st_ff.flags[3])
    else $error("zero write beat event");

  chk_duty_or_merge: assert property ( // R5
    cyc_m && wr_duty && !stby_in |=>
    st_ff.duty == ($past(st_ff.duty_buf) | $past(WDATA_I)))
    else $error("duty collision not merged");

  chk_dma_clear_wins: assert property ( // R7
    DMA_CLR_I[0] && !stby_in |=> !st_ff.flags[0] && !st_ff.farm[0])
    else $error("dma clear lost");

  chk_underflow_halt: assert property ( // R12
    unf_s |=> st_ff.os == OS_IDLE && st_ff.dflag &&
    st_ff.one_shot_down_counter == 16'h0000 && !st_ff.osp)
    else $error("underflow halt wrong");

  chk_zero_start: assert property ( // R10
    zero_start_s |=> !st_ff.osp && st_ff.os == OS_RUN)
    else $error("zero start gave pulse");

  chk_start_lost: assert property ( // R13
    unf_s ##0 wr_dstart |=> st_ff.os == OS_IDLE)
    else $error("start beat underflow");

  chk_capture_idle: assert property ( // R11
    cap0_ev && !st_ff.run[0] && !DMA_CLR_I[0] && !stby_in |=>
    st_ff.flags[0] && st_ff.icr0 == $past(st_ff.cnt0))
    else $error("capture skipped while halted");

  chk_interval_edge: assert property ( // R18
    wr_cnt0 && !st_ff.cnt0[10] && WDATA_I[10] && st_ff.ctrl[4] &&
    !stby_in |=> ITV_IRQ_O)
    else $error("interval edge missed");

  chk_repeat_disarm: assert property ( // R20
    unf_s ##0 (st_ff.dflag && !RD_I) |=> !st_ff.darm)
    else $error("repeat underflow left clear armed");

  chk_standby_clear: assert property ( // R21
    stby_in |=> st_ff.cnt0 == 16'h0000 && st_ff.run == 3'h0 &&
    !st_ff.pwm_out && !st_ff.osp)
    else $error("standby left state set");

endmodule // multi_channel_timer

// ==== multi_channel_timer_pkg.sv ====
package multi_channel_timer_pkg;
  // ========================================================================
  // one-shot down-counter state
  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_RUN  = 2'b10
  } os_state_t;

  // ========================================================================
  // complete register state of the timer
  typedef struct packed {
    logic [7:0]  pre_cnt;
    logic [7:0]  psc;
    logic [2:0]  run;
    logic [11:0] ctrl;
    logic [15:0] cnt0;
    logic [15:0] icr0;
    logic [15:0] cnt1;
    logic [15:0] gr1;
    logic [15:0] cnt2;
    logic [15:0] cyc;
    logic [15:0] duty_buf;
    logic [15:0] duty;
    logic [15:0] one_shot_down_counter;
    os_state_t   os;
    logic        osp;
    logic        cmp_out;
    logic        pwm_out;
    logic [3:0]  flags;
    logic [3:0]  farm;
    logic        dflag;
    logic        darm;
    logic        itv_irq;
    logic        ad_start;
    logic        stby_d;
    logic [15:0] rd_data;
  } tmr_state_t;
endpackage

// ==== multi_channel_timer_regs.svh ====
`ifndef MULTI_CHANNEL_TIMER_REGS_SVH
`define MULTI_CHANNEL_TIMER_REGS_SVH
// ==========================================================================
// register byte offsets
`define TMR_RUN      8'h00
`define TMR_PSC      8'h04
`define TMR_CTRL     8'h08
`define TMR_CNT0     8'h0C
`define TMR_ICR0     8'h10
`define TMR_CNT1     8'h14
`define TMR_GR1      8'h18
`define TMR_CNT2     8'h1C
`define TMR_CYC      8'h20
`define TMR_BUF      8'h24
`define TMR_DUTY     8'h28
`define TMR_ONE_SHOT_DOWN_COUNTER     8'h2C
`define TMR_DSTART   8'h30
`define TMR_FLAGS    8'h34
`define TMR_DFLAG    8'h38
`define TMR_STATUS   8'h3C
// ==========================================================================
// control field positions
`define CTRL_CLR1    0
`define CTRL_CAPMODE 1
`define CTRL_LINK    2
`define CTRL_ITVE    4
`define CTRL_ITVAD   8
`define ITV_LSB      10
`define ITV_BITS     4
// ==========================================================================
// flag positions
`define FLG_CAP0     0
`define FLG_MATCH1   1
`define FLG_WRAP1    2
`define FLG_CYC2     3
// ==========================================================================
// reset values
`define RST_PSC      8'h00
`define RST_WORD     16'h0000
`endif

// ==== multi_channel_timer_tb_top.sv ====
`timescale 1ns/10ps
`include "multi_channel_timer_regs.svh"
module multi_channel_timer_tb_top
  import multi_channel_timer_pkg::*;
;
  // ========================================================================
  // signals
  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        cap0;
  logic        cap1;
  logic [3:0]  dma_clr;
  logic        stby;
  logic        cmp1;
  logic        pwm;
  logic        osp;
  logic        itv;
  logic        ads;
  logic        dstart;
  logic [3:0]  dlen;
  logic [15:0] itv_n;
  logic [15:0] ads_n;
  logic [15:0] osp_n;
  logic [15:0] pwm_n;
  logic [15:0] ads_base;
  logic [15:0] got;
  logic [15:0] base;
  int          miscompares;
  int          samples_checked;

  // ========================================================================
  // instances
  multi_channel_timer u_dut (
    .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CAP0_I(cap0), .CAP1_I(cap1),
    .DMA_CLR_I(dma_clr), .STBY_I(stby), .CMP1_O(cmp1), .PWM_O(pwm),
    .OSP_O(osp), .ITV_IRQ_O(itv), .AD_START_O(ads)
  );
  dma_clear_model u_dma (
    .CLK_I(clk), .RST_B_I(rst_b), .start_i(dstart), .bits_i(4'h1),
    .len_i(dlen), .dma_clr_o(dma_clr)
  );

  // ========================================================================
  // clock and counters of cycles itv, ads, osp and pwm are high
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst_b) begin
      itv_n <= itv_n + {15'h0, itv};
      ads_n <= ads_n + {15'h0, ads};
      osp_n <= osp_n + {15'h0, osp};
      pwm_n <= pwm_n + {15'h0, pwm};
    end
  end

  // ========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic cap_pulse;
    cap0 <= 1'b1;
    idle(5);
    cap0 <= 1'b0;
    idle(2);
  endtask
  task automatic dma_go(input logic [3:0] n);
    dlen   <= n;
    dstart <= 1'b1;
    @(posedge clk);
    dstart <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset;
    rd_reg(`TMR_CNT0, got);
    chk(got, `RST_WORD);
    rd_reg(`TMR_PSC, got);
    chk(got, {8'h00, `RST_PSC});
    rd_reg(8'hFC, got);
    chk(got, 16'h0000);
    chk({11'h0, osp, pwm, cmp1, itv, ads}, 16'h0000);
    $display("done: reset");
  endtask
  task automatic t_capture;
    wr_reg(`TMR_CNT0, 16'h1234);
    cap_pulse();
    rd_reg(`TMR_ICR0, got);
    chk(got, 16'h1234);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0001);
    wr_reg(`TMR_FLAGS, 16'h0000);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0000);
    $display("done: capture");
  endtask
  task automatic t_count;
    wr_reg(`TMR_PSC, 16'h0000);
    wr_reg(`TMR_RUN, 16'h0001);
    wr_reg(`TMR_CNT0, 16'h5555);
    rd_reg(`TMR_CNT0, got);
    chk(got, 16'h5556);
    wr_reg(`TMR_RUN, 16'h0000);
    wr_reg(`TMR_CNT0, 16'h00AA);
    idle(4);
    rd_reg(`TMR_CNT0, got);
    chk(got, 16'h00AA);
    $display("done: count");
  endtask
  task automatic t_interval;
    wr_reg(`TMR_CTRL, 16'h0110);
    wr_reg(`TMR_CNT0, 16'h0000);
    base = itv_n;
    ads_base = ads_n;
    wr_reg(`TMR_CNT0, 16'h0400);
    idle(3);
    chk(itv_n - base, 16'h0001);
    chk(ads_n - ads_base, 16'h0001);
    wr_reg(`TMR_CNT0, 16'h0800);
    idle(3);
    chk(itv_n - base, 16'h0001);
    $display("done: interval");
  endtask
  task automatic t_dma;
    dma_go(4'h8);
    cap_pulse();
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0000);
    cap_pulse();
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0001);
    dma_go(4'h2);
    idle(3);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0000);
    $display("done: dma");
  endtask
  task automatic t_down;
    base = osp_n;
    wr_reg(`TMR_DSTART, 16'h0001);
    idle(4);
    chk(osp_n - base, 16'h0000);
    rd_reg(`TMR_DFLAG, got);
    chk(got, 16'h0001);
    wr_reg(`TMR_DSTART, 16'h0001);
    idle(2);
    wr_reg(`TMR_DFLAG, 16'h0000);
    rd_reg(`TMR_DFLAG, got);
    chk(got, 16'h0001);
    wr_reg(`TMR_DFLAG, 16'h0000);
    rd_reg(`TMR_DFLAG, got);
    chk(got, 16'h0000);
    wr_reg(`TMR_ONE_SHOT_DOWN_COUNTER, 16'h0020);
    wr_reg(`TMR_DSTART, 16'h0001);
    idle(2);
    wr_reg(`TMR_ONE_SHOT_DOWN_COUNTER, 16'h0000);
    idle(4);
    rd_reg(`TMR_DSTART, got);
    chk(got, 16'h0000);
    rd_reg(`TMR_DFLAG, got);
    chk(got, 16'h0001);
    chk({15'h0, osp_n != base}, 16'h0001);
    wr_reg(`TMR_ONE_SHOT_DOWN_COUNTER, 16'h0001);
    wr_reg(`TMR_DSTART, 16'h0001);
    wr_reg(`TMR_DSTART, 16'h0001);
    rd_reg(`TMR_DSTART, got);
    chk(got, 16'h0000);
    $display("done: down");
  endtask
  task automatic t_pwm;
    wr_reg(`TMR_CYC, 16'h0004);
    wr_reg(`TMR_BUF, 16'h0002);
    wr_reg(`TMR_DUTY, 16'h0002);
    wr_reg(`TMR_RUN, 16'h0004);
    idle(3);
    wr_reg(`TMR_DUTY, 16'h0001);
    rd_reg(`TMR_DUTY, got);
    chk(got, 16'h0003);
    wr_reg(`TMR_BUF, 16'h0001);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0008);
    idle(2);
    wr_reg(`TMR_FLAGS, 16'h0000);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0008);
    base = pwm_n;
    idle(20);
    chk(pwm_n - base, 16'h0008);
    $display("done: pwm");
  endtask
  task automatic t_standby;
    wr_reg(`TMR_GR1, 16'h0002);
    wr_reg(`TMR_RUN, 16'h0002);
    wr_reg(`TMR_CNT0, 16'h00AA);
    stby <= 1'b1;
    idle(3);
    chk({15'h0, cmp1}, 16'h0001);
    chk({15'h0, pwm}, 16'h0000);
    stby <= 1'b0;
    idle(3);
    rd_reg(`TMR_CNT0, got);
    chk(got, 16'h0000);
    chk({15'h0, cmp1}, 16'h0000);
    $display("done: standby");
  endtask
  task automatic t_chan1;
    wr_reg(`TMR_CTRL, 16'h0002);
    cap1 <= 1'b1;
    idle(2);
    wr_reg(`TMR_GR1, 16'h1357);
    cap1 <= 1'b0;
    rd_reg(`TMR_GR1, got);
    chk(got, 16'h1357);
    wr_reg(`TMR_CNT1, 16'hFFFE);
    wr_reg(`TMR_RUN, 16'h0002);
    wr_reg(`TMR_CNT1, 16'h5555);
    rd_reg(`TMR_CNT1, got);
    chk(got, 16'h5556);
    wr_reg(`TMR_RUN, 16'h0000);
    rd_reg(`TMR_FLAGS, got);
    chk(got, 16'h0006);
    $display("done: chan1");
  endtask

  // ========================================================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0; addr = 8'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    cap0 = 1'b0; cap1 = 1'b0; stby = 1'b0; dstart = 1'b0; dlen = 4'h2;
    itv_n = 16'h0; ads_n = 16'h0; osp_n = 16'h0; pwm_n = 16'h0;
    miscompares = 0; samples_checked = 0;
    idle(2);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_capture();
    t_count();
    t_interval();
    t_dma();
    t_down();
    t_pwm();
    t_standby();
    t_chan1();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule // multi_channel_timer_tb_top
